// *** tb/lcs_probe_model.sv ***
// stand-in for the circuit under test that drives the sixteen probe levels
`timescale 1ns/1ps
`default_nettype none
module lcs_probe_model (
  input wire logic sys_clk,
  input wire logic [15:0] pattern,
  input wire logic [7:0] hi_lvl,
  input wire logic tog_en,
  input wire logic [3:0] tog_ch,
  output logic [127:0] logic_input_lines,
  output int rises,
  output int falls
);
  logic tog_q = 1'b0;
  logic [2:0] div_q = 3'h0;
  logic [15:0] eff;
  // slow target clock: one toggle every four cycles keeps edges well apart
  always_ff @(posedge sys_clk) begin
    div_q <= tog_en ? div_q + 3'h1 : 3'h0;
    if (tog_en && div_q[1:0] == 2'h3) begin
      tog_q <= ~tog_q;
      rises <= rises + int'(!tog_q);
      falls <= falls + int'(tog_q);
    end
  end
  // low level is ground; high level is set by the bench to probe the windows
  assign eff = pattern ^ (16'(tog_q) << tog_ch);
  for (genvar c = 0; c < 16; c++) begin : g_ch
    assign logic_input_lines[8*c+:8] = eff[c] ? hi_lvl : 8'h00;
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench of the logic channel sampler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [127:0] lines;
  logic [15:0] chan_bits;
  logic [3:0] dec_valid;
  logic irq;
  logic [15:0] pattern = 16'h0;
  logic [7:0] hi_lvl = 8'hff;
  logic tog_en = 1'b0;
  logic [3:0] tog_ch = 4'h4;
  int rises, falls, fail_count, check_count, nvalid, a0, a1, b0;
  logic [31:0] rd, t0;
  logic err;
  // rows: hysteresis mode, level on every channel, expected bit (state carries over)
  logic [10:0] rows [13] = '{{2'h0, 8'h00, 1'b0}, {2'h0, 8'h83, 1'b1}, {2'h0, 8'h7e, 1'b1},
    {2'h0, 8'h7d, 1'b0}, {2'h0, 8'h82, 1'b0}, {2'h1, 8'h90, 1'b0}, {2'h1, 8'h91, 1'b1},
    {2'h1, 8'h70, 1'b1}, {2'h1, 8'h6f, 1'b0}, {2'h2, 8'h84, 1'b0}, {2'h2, 8'h85, 1'b1},
    {2'h2, 8'h74, 1'b1}, {2'h2, 8'h73, 1'b0}};

  lcs_sampler u_lcs_sampler (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .logic_input_lines(lines), .chan_bits(chan_bits),
    .dec_valid(dec_valid), .irq(irq));
  lcs_probe_model u_lcs_probe_model (.sys_clk(sys_clk), .pattern(pattern), .hi_lvl(hi_lvl),
    .tog_en(tog_en), .tog_ch(tog_ch), .logic_input_lines(lines), .rises(rises),
    .falls(falls));

  always #4 sys_clk = ~sys_clk;
  // decode pulses of the clocked group, counted by non-blocking update to avoid races
  always @(posedge sys_clk) begin
    if (dec_valid[2] === 1'b1) nvalid <= nvalid + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready with a bound, never assumes the latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // cycles until channels 0 and 1 follow a rising step
  task automatic meas(output int f0, output int f1);
    f0 = 0;
    f1 = 0;
    pattern <= 16'h0;
    repeat (40) @(posedge sys_clk);
    pattern <= 16'h0003;
    // sampled mid-cycle so the edge that launches chan_bits is never raced
    for (int n = 1; n < 80; n++) begin
      @(negedge sys_clk);
      if (f0 == 0 && chan_bits[0] === 1'b1) f0 = n;
      if (f1 == 0 && chan_bits[1] === 1'b1) f1 = n;
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog sized well beyond the roughly 1400 cycles the tests need
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    chk({14'h0, irq, |dec_valid, chan_bits}, 32'h0);
    rst_n <= 1'b1;
    rchk(lcs_pkg::OFF_CTRL, 32'h7);
    rchk(lcs_pkg::OFF_THR, 32'h80);
    pattern <= 16'hffff;
    foreach (rows[i]) begin
      apb(1'b1, lcs_pkg::OFF_CTRL, {26'h0, rows[i][10:9], 4'h7});
      hi_lvl <= rows[i][8:1];
      repeat (40) @(posedge sys_clk);
      chk({16'h0, chan_bits}, {16'h0, {16{rows[i][0]}}});
    end
    for (int k = 1; k < 8; k++) begin
      apb(1'b1, lcs_pkg::OFF_TECH, 32'(k));
      rchk(lcs_pkg::OFF_THR, {24'h0, lcs_pkg::TECH_THR[k]});
    end
    apb(1'b1, lcs_pkg::OFF_THR, 32'h80);
    rchk(lcs_pkg::OFF_TECH, 32'h0);
    // pod enables, one pod at a time
    hi_lvl <= 8'hff;
    apb(1'b1, lcs_pkg::OFF_CTRL, 32'h5);
    repeat (40) @(posedge sys_clk);
    chk({16'h0, chan_bits}, 32'hff00);
    apb(1'b1, lcs_pkg::OFF_CTRL, 32'h3);
    repeat (40) @(posedge sys_clk);
    chk({16'h0, chan_bits}, 32'h00ff);
    apb(1'b1, lcs_pkg::OFF_CTRL, 32'h7);
    // skew: channel 1 delayed by 3, then a common delay of 2 on top
    apb(1'b1, lcs_pkg::OFF_SKLO, 32'h30);
    meas(a0, a1);
    chk(32'(a1 - a0), 32'd3);
    apb(1'b1, lcs_pkg::OFF_SKEW, 32'h2);
    meas(b0, a1);
    chk(32'(b0 - a0), 32'd2);
    // overlapping enable knocks out the older group and flags it
    pattern <= 16'hffff;
    apb(1'b1, 8'h40, 32'h000f_0001);
    repeat (40) @(posedge sys_clk);
    rchk(8'h48, 32'h0000_000f);
    apb(1'b1, 8'h50, 32'h8001_0009);
    repeat (8) @(posedge sys_clk);
    rchk(8'h40, 32'h000f_0000);
    rchk(lcs_pkg::OFF_STAT, 32'h10);
    rchk(8'h58, 32'hffff_8001);
    apb(1'b1, 8'h50, 32'h8001_0001);
    repeat (8) @(posedge sys_clk);
    rchk(8'h58, 32'h0000_8001);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, lcs_pkg::OFF_MASK, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, lcs_pkg::OFF_STAT, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    // clocked group on channel 4, rising then falling slope
    for (int s = 0; s < 2; s++) begin
      apb(1'b0, lcs_pkg::OFF_TIME, 32'h0);
      t0 = rd;
      apb(1'b1, 8'h60, {16'h00f0, 8'h00, 4'h4, 1'b0, s[0], 2'h3});
      pattern <= 16'h00a0;
      repeat (40) @(posedge sys_clk);
      a0 = nvalid;
      b0 = s ? falls : rises;
      tog_en <= 1'b1;
      repeat (64) @(posedge sys_clk);
      tog_en <= 1'b0;
      repeat (40) @(posedge sys_clk);
      chk(32'(nvalid - a0), 32'((s ? falls : rises) - b0));
      apb(1'b0, 8'h68, 32'h0);
      chk(rd & 32'he0, 32'ha0);
      apb(1'b0, 8'h6c, 32'h0);
      chk({31'h0, rd > t0}, 32'h1);
    end
    // uncoupled: every enabled group's channels take the last enabled group's threshold
    apb(1'b1, 8'h74, 32'hc0);
    apb(1'b1, 8'h70, 32'h0f00_0001);
    apb(1'b1, lcs_pkg::OFF_CTRL, 32'h6);
    pattern <= 16'hffff;
    hi_lvl <= 8'ha0;
    repeat (40) @(posedge sys_clk);
    chk({16'h0, chan_bits}, 32'h0000_700e);
    apb(1'b0, lcs_pkg::OFF_TIME, 32'h0);
    t0 = rd;
    rchk(lcs_pkg::OFF_TIME, t0 + 32'd3);
    // unmapped address is refused with an error and zero data
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // second reset in mid-run
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({14'h0, irq, |dec_valid, chan_bits}, 32'h0);
    rst_n <= 1'b1;
    rchk(lcs_pkg::OFF_CTRL, 32'h7);
    complete_run();
  end
endmodule
`default_nettype wire

// *** verilog/lcs_pkg.sv ***
// constants and register map of the logic channel sampler
// What this block does
// - sixteen channels in two pods of eight
// - four configurable logic groups of channels
// - a channel joins one enabled group only
// - conflicting enable disables other group, flags
// - above threshold records one, below zero
// - hysteresis modes normal, maximum, robust
// - thresholds coupled for all after reset
// - enabled groups share last enabled settings
// - preset loads threshold; direct entry means manual
// - unclocked every sample, clocked on edges
// - clocked group picks clock channel, slope
// - clocked group logs word and time
// - integer bus values at most sixteen bits
// - binary output signed only when signed
// - per-channel programmable delay
// - one common delay for all channels
// - one enable per pod of eight
package lcs_pkg;
  localparam int NUM_CH = 16;
  localparam int POD_CH = 8;
  localparam int NUM_GRP = 4;
  localparam int LVL_W = 8;
  localparam int DLY_W = 4;
  localparam int HIST_D = 32;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_THR = 8'h04;
  localparam logic [7:0] OFF_TECH = 8'h08;
  localparam logic [7:0] OFF_SKEW = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_TIME = 8'h18;
  localparam logic [7:0] OFF_SKLO = 8'h1c;
  localparam logic [7:0] OFF_SKHI = 8'h20;
  localparam logic [7:0] OFF_GRP = 8'h40;
  localparam logic [3:0] GRP_CFG = 4'h0;
  localparam logic [3:0] GRP_THR = 4'h4;
  localparam logic [3:0] GRP_WORD = 4'h8;
  localparam logic [3:0] GRP_TIME = 4'hc;
  // cfg fields
  localparam int CFG_EN = 0;
  localparam int CFG_CLK = 1;
  localparam int CFG_SLOPE = 2;
  localparam int CFG_SIGNED = 3;
  localparam int CFG_SRC = 4;
  localparam int CFG_MEM = 16;
  localparam int STAT_CONF = 4;
  localparam logic CTRL_COUPLE_RST = 1'b1;
  localparam logic [1:0] POD_EN_RST = 2'h3;
  localparam logic [7:0] THR_RST = 8'h80;
  typedef enum logic [1:0] {
    LCS_HYS_NORM = 2'b00,
    LCS_HYS_MAX = 2'b01,
    LCS_HYS_ROB = 2'b10
  } lcs_hys_t;
  localparam logic [7:0] HYS_NORM_W = 8'h02;
  localparam logic [7:0] HYS_MAX_W = 8'h10;
  localparam logic [7:0] HYS_ROB_UP = 8'h04;
  localparam logic [7:0] HYS_ROB_DN = 8'h0c;
  // technology presets, code 0 is manual
  localparam logic [7:0] TECH_THR [8] = '{8'h00, 8'h40, 8'h60, 8'h80,
                                          8'ha0, 8'h30, 8'h50, 8'h70};
endpackage

// *** verilog/lcs_sampler.sv ***
// logic channel sampler: thresholds, skew, groups and decode log
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lcs_sampler #(
  parameter int NUM_CH = lcs_pkg::NUM_CH,
  parameter int NUM_GRP = lcs_pkg::NUM_GRP
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH*lcs_pkg::LVL_W-1:0] logic_input_lines,
  output logic [NUM_CH-1:0] chan_bits,
  output logic [NUM_GRP-1:0] dec_valid,
  output logic irq
);
  localparam int LW = lcs_pkg::LVL_W;
  localparam int DW = lcs_pkg::DLY_W;

  // register state
  logic couple_q;
  logic [1:0] pod_en_q;
  logic [1:0] ghys_q;
  logic [7:0] gthr_q;
  logic [2:0] tech_q;
  logic [DW-1:0] cskew_q;
  logic [DW-1:0] skew_q [NUM_CH];
  logic [4:0] stat_q;
  logic [4:0] mask_q;
  logic [31:0] ts_q;
  logic [31:0] cfg_q [NUM_GRP];
  logic [9:0] gth_q [NUM_GRP];
  logic [15:0] word_q [NUM_GRP];
  logic [31:0] time_q [NUM_GRP];
  logic [NUM_GRP-1:0] dec_q;
  logic [NUM_GRP-1:0] prev_q;
  logic [7:0] athr_q;
  logic [1:0] ahys_q;
  logic [NUM_CH-1:0] lvl_q;
  logic [lcs_pkg::HIST_D-1:0] hist_q [NUM_CH];

  // apb decode
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire grp_hit = (paddr >= lcs_pkg::OFF_GRP) && (paddr < 8'h80);
  wire [1:0] grp_idx = paddr[5:4];
  wire [3:0] grp_off = paddr[3:0];
  wire glb_hit = (paddr <= lcs_pkg::OFF_SKHI) && (paddr[1:0] == 2'h0);
  wire addr_ok = glb_hit | (grp_hit & (paddr[1:0] == 2'h0));
  wire wr_cfg = apb_wr & grp_hit & (grp_off == lcs_pkg::GRP_CFG);
  wire wr_gthr = apb_wr & grp_hit & (grp_off == lcs_pkg::GRP_THR);
  wire wr_thr = apb_wr & (paddr == lcs_pkg::OFF_THR);
  wire wr_tech = apb_wr & (paddr == lcs_pkg::OFF_TECH);
  wire wr_stat = apb_wr & (paddr == lcs_pkg::OFF_STAT);
  wire new_en = pwdata[lcs_pkg::CFG_EN];
  wire [15:0] new_mem = pwdata[31:16];
  assign pready = 1'b1; // zero wait states
  assign pslverr = apb_acc & ~addr_ok;

  // group status and conflict detection
  logic [NUM_GRP-1:0] grp_en;
  logic [NUM_GRP-1:0] kill_w;
  logic [NUM_GRP-1:0] edge_w;
  logic [15:0] mem_w [NUM_GRP];
  logic [NUM_CH-1:0] in_grp;
  logic [NUM_CH-1:0] chan_w;
  logic [15:0] gword_w [NUM_GRP];
  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++) begin : gen_grp
      wire [3:0] src = cfg_q[g][lcs_pkg::CFG_SRC +: 4];
      wire clk_bit = chan_w[src];
      assign mem_w[g] = cfg_q[g][lcs_pkg::CFG_MEM +: 16];
      assign grp_en[g] = cfg_q[g][lcs_pkg::CFG_EN];
      // other enabled group sharing a channel is switched off
      assign kill_w[g] = wr_cfg & new_en & (grp_idx != 2'(g)) & grp_en[g]
                         & |(mem_w[g] & new_mem);
      // qualifying edge of the chosen clock channel
      assign edge_w[g] = grp_en[g] & cfg_q[g][lcs_pkg::CFG_CLK] &
                         (cfg_q[g][lcs_pkg::CFG_SLOPE] ? (prev_q[g] & ~clk_bit)
                                                        : (~prev_q[g] & clk_bit));
      assign gword_w[g] = chan_w & mem_w[g]; // 16 bits at most
    end
  endgenerate
  wire any_kill = |kill_w;

  // membership across enabled groups selects the threshold source
  always_comb begin
    in_grp = '0;
    for (int k = 0; k < NUM_GRP; k++) begin
      if (grp_en[k]) begin
        in_grp = in_grp | mem_w[k];
      end
    end
  end

  // per-channel comparator with hysteresis and delay line
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : gen_ch
      wire [LW-1:0] lvl = logic_input_lines[c*LW +: LW];
      wire use_act = ~couple_q & in_grp[c]; // coupled: one setting for all
      wire [7:0] thr = use_act ? athr_q : gthr_q;
      wire [1:0] hys = use_act ? ahys_q : ghys_q;
      // robust splits the window, so rising and falling differ
      wire [7:0] hup = (hys == lcs_pkg::LCS_HYS_MAX) ? lcs_pkg::HYS_MAX_W :
                       (hys == lcs_pkg::LCS_HYS_ROB) ? lcs_pkg::HYS_ROB_UP :
                       lcs_pkg::HYS_NORM_W;
      wire [7:0] hdn = (hys == lcs_pkg::LCS_HYS_MAX) ? lcs_pkg::HYS_MAX_W :
                       (hys == lcs_pkg::LCS_HYS_ROB) ? lcs_pkg::HYS_ROB_DN :
                       lcs_pkg::HYS_NORM_W;
      wire above = {1'b0, lvl} > ({1'b0, thr} + {1'b0, hup});
      wire below = ({1'b0, lvl} + {1'b0, hdn}) < {1'b0, thr};
      wire lvl_d = above ? 1'b1 : (below ? 1'b0 : lvl_q[c]);
      wire [DW:0] dly = {1'b0, skew_q[c]} + {1'b0, cskew_q};
      // pod switch gates all eight channels together
      assign chan_w[c] = hist_q[c][dly] & pod_en_q[c / lcs_pkg::POD_CH];
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          lvl_q[c] <= 1'b0;
          hist_q[c] <= '0;
        end else begin
          lvl_q[c] <= lvl_d;
          hist_q[c] <= {hist_q[c][lcs_pkg::HIST_D-2:0], lvl_d};
        end
      end
    end
  endgenerate
  assign chan_bits = chan_w;

  // global control registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      couple_q <= lcs_pkg::CTRL_COUPLE_RST;
      pod_en_q <= lcs_pkg::POD_EN_RST;
      ghys_q <= 2'h0;
      gthr_q <= lcs_pkg::THR_RST;
      tech_q <= 3'h0;
      cskew_q <= '0;
      mask_q <= 5'h00;
    end else if (apb_wr) begin
      if (paddr == lcs_pkg::OFF_CTRL) begin
        couple_q <= pwdata[0];
        pod_en_q <= pwdata[2:1];
        ghys_q <= pwdata[5:4];
      end
      if (wr_thr) begin
        gthr_q <= pwdata[7:0];
        tech_q <= 3'h0; // direct entry is manual
      end
      if (wr_tech) begin
        tech_q <= pwdata[2:0];
        if (pwdata[2:0] != 3'h0) begin
          gthr_q <= lcs_pkg::TECH_THR[pwdata[2:0]];
        end
      end
      if (paddr == lcs_pkg::OFF_SKEW) begin
        cskew_q <= pwdata[DW-1:0];
      end
      if (paddr == lcs_pkg::OFF_MASK) begin
        mask_q <= pwdata[4:0];
      end
    end
  end

  // channel skew registers, two words of eight nibbles
  always_ff @(posedge sys_clk) begin
    for (int k = 0; k < NUM_CH; k++) begin
      if (!rst_n) begin
        skew_q[k] <= '0;
      end else if (apb_wr && paddr == ((k < 8) ? lcs_pkg::OFF_SKLO : lcs_pkg::OFF_SKHI)) begin
        skew_q[k] <= pwdata[(k % 8)*DW +: DW];
      end
    end
  end

  // group configuration; enabling copies its settings to the shared set
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      athr_q <= lcs_pkg::THR_RST;
      ahys_q <= 2'h0;
      for (int k = 0; k < NUM_GRP; k++) begin
        cfg_q[k] <= '0;
        gth_q[k] <= {2'h0, lcs_pkg::THR_RST};
      end
    end else begin
      for (int k = 0; k < NUM_GRP; k++) begin
        if (kill_w[k]) begin
          cfg_q[k][lcs_pkg::CFG_EN] <= 1'b0;
        end
        if (wr_cfg && grp_idx == 2'(k)) begin
          cfg_q[k] <= pwdata;
          if (new_en) begin
            athr_q <= gth_q[k][7:0]; // last enabled wins
            ahys_q <= gth_q[k][9:8];
          end
        end
        if (wr_gthr && grp_idx == 2'(k)) begin
          gth_q[k] <= pwdata[9:0];
        end
      end
    end
  end

  // bus capture, decode entries and free-running timestamp
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ts_q <= '0;
      dec_q <= '0;
      prev_q <= '0;
      for (int k = 0; k < NUM_GRP; k++) begin
        word_q[k] <= '0;
        time_q[k] <= '0;
      end
    end else begin
      ts_q <= ts_q + 32'h1;
      for (int k = 0; k < NUM_GRP; k++) begin
        prev_q[k] <= chan_w[cfg_q[k][lcs_pkg::CFG_SRC +: 4]];
        dec_q[k] <= edge_w[k];
        if (grp_en[k] && !cfg_q[k][lcs_pkg::CFG_CLK]) begin
          word_q[k] <= gword_w[k]; // every sample
        end
        if (edge_w[k]) begin
          word_q[k] <= gword_w[k];
          time_q[k] <= ts_q;
        end
      end
    end
  end
  assign dec_valid = dec_q;

  // sticky status, set wins over write-one-clear
  wire [4:0] stat_set = {any_kill, edge_w[3:0]};
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_q <= 5'h00;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? pwdata[4:0] : 5'h00)) | stat_set;
    end
  end
  assign irq = |(stat_q & mask_q);

  // read data; signed groups sign-extend for binary readout
  wire [31:0] gcfg_r = cfg_q[grp_idx];
  wire [15:0] gw_r = word_q[grp_idx];
  wire gsig = gcfg_r[lcs_pkg::CFG_SIGNED];
  wire [31:0] gword_r = gsig ? {{16{gw_r[15]}}, gw_r} : {16'h0000, gw_r};
  wire [31:0] grp_r = (grp_off == lcs_pkg::GRP_CFG) ? gcfg_r :
                      (grp_off == lcs_pkg::GRP_THR) ? {22'h0, gth_q[grp_idx]} :
                      (grp_off == lcs_pkg::GRP_WORD) ? gword_r : time_q[grp_idx];
  wire [31:0] skw_lo = {skew_q[7], skew_q[6], skew_q[5], skew_q[4],
                        skew_q[3], skew_q[2], skew_q[1], skew_q[0]};
  wire [31:0] skw_hi = {skew_q[15], skew_q[14], skew_q[13], skew_q[12],
                        skew_q[11], skew_q[10], skew_q[9], skew_q[8]};
  logic [31:0] glb_r;
  always_comb begin
    unique case (paddr)
      lcs_pkg::OFF_CTRL: glb_r = {26'h0, ghys_q, 1'b0, pod_en_q, couple_q};
      lcs_pkg::OFF_THR: glb_r = {24'h0, gthr_q};
      lcs_pkg::OFF_TECH: glb_r = {29'h0, tech_q};
      lcs_pkg::OFF_SKEW: glb_r = {28'h0, cskew_q};
      lcs_pkg::OFF_STAT: glb_r = {27'h0, stat_q};
      lcs_pkg::OFF_MASK: glb_r = {27'h0, mask_q};
      lcs_pkg::OFF_TIME: glb_r = ts_q;
      lcs_pkg::OFF_SKLO: glb_r = skw_lo;
      lcs_pkg::OFF_SKHI: glb_r = skw_hi;
      default: glb_r = 32'h0;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= grp_hit ? grp_r : glb_r; // latched in setup, valid in access
    end
  end

  // checks
  logic [NUM_GRP-1:0] ovl_w;
  always_comb begin
    ovl_w = '0;
    for (int a = 0; a < NUM_GRP; a++) begin
      for (int b = 0; b < NUM_GRP; b++) begin
        if (a != b && grp_en[a] && grp_en[b] && |(mem_w[a] & mem_w[b])) begin
          ovl_w[a] = 1'b1;
        end
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_no_overlap: assert property (##1 ovl_w == '0)
    else $error("channel in two enabled groups");
  a_conflict_flag: assert property (any_kill |=> stat_q[4] && (grp_en & $past(kill_w)) == '0)
    else $error("conflict not flagged or group kept");
  a_thr_one: assert property (couple_q && logic_input_lines[7:0] > gthr_q + 8'h12 &&
                              gthr_q < 8'hd0 |=> lvl_q[0])
    else $error("high level not recorded as one");
  a_couple_reset: assert property ($rose(rst_n) |-> couple_q && pod_en_q == 2'h3)
    else $error("not coupled after reset");
  a_tech_manual: assert property (wr_thr && !wr_tech |=> tech_q == 3'h0)
    else $error("direct threshold did not select manual");
  a_clocked_hold: assert property (grp_en[0] && cfg_q[0][1] && !edge_w[0] && !wr_cfg
                                   |=> $stable(word_q[0]))
    else $error("clocked word changed without edge");
  a_edge_logs: assert property (edge_w[0] |=> dec_valid[0] && time_q[0] == $past(ts_q))
    else $error("edge not logged with its time");
  a_pod_off: assert property (pod_en_q[0] == 1'b0 |-> chan_w[7:0] == 8'h00)
    else $error("disabled pod passes data");
  a_ts_runs: assert property (1'b1 |=> ts_q == $past(ts_q) + 32'h1)
    else $error("timestamp not free running");
endmodule
`default_nettype wire
